// [shared/tsf_reg_map.svh]
// Purpose: register map, field positions and timing figures of the transceiver status flag logic
// Assumes: 250 MHz system clock, APB with 32-bit data
// Notes: included by bare name; definitions only
//
// Notes on behaviour
// - a local rouse event is taken on either edge of the wake input
// - every active fault condition is ORed into the active-low fault indicator
// - a pending rouse request is also shown low on the receive-data output in standby
// - cold start sets on battery power-up and on battery recovery from undervoltage
// - cold start pulls the fault indicator low on silent entry from standby or sleep
// - cold start clears only after a transition into normal mode
// - cold start also sets rouse request and a local rouse source in standby, go-to-sleep or sleep
// - after a rouse, standby drives fault and rxd low; normal or supply undervoltage clears it
// - rouse request sets only in standby, go-to-sleep or sleep; it restarts undervoltage timers
// - rouse source records bus activity, wake input edge or power-up
// - in normal mode fault shows the source: low local, high remote, until cleared
// - rouse source clears after four txd falls in normal, leaving normal, or undervoltage
// - a mask input change sets the mask flag, shown low in silent mode
// - mask flag clears on entering normal, standby, go-to-sleep or sleep
// - supply undervoltage flags stay internal; set while the supply is low, clear only on supply recovery
// - go-to-sleep is refused while the rouse request flag is set
// - the first recorded rouse source is kept until the flag clears
// - the fault indicator is released to high impedance in sleep mode
`ifndef TSF_REG_MAP_SVH
`define TSF_REG_MAP_SVH

// ****************************************
// register offsets and reset values
// ****************************************
`define TSF_ADDR_W 12
`define TSF_OFF_CTRL 12'h000
`define TSF_OFF_STATUS 12'h004
`define TSF_CTRL_RST 32'h0000_0003
`define TSF_CTRL_W 2

// ****************************************
// field positions
// ****************************************
`define TSF_CTRL_LOCAL_EN 0
`define TSF_CTRL_BUS_EN 1
`define TSF_ST_COLD 0
`define TSF_ST_REQ 1
`define TSF_ST_SRC_LO 2
`define TSF_ST_SRC_HI 3
`define TSF_ST_MASK 4
`define TSF_ST_UVC 5
`define TSF_ST_UVI 6
`define TSF_ST_MODE_LO 8
`define TSF_ST_MODE_HI 10

// ****************************************
// timing
// ****************************************
`define TSF_CLK_MHZ 250
`define TSF_UV_FILTER_NS 100000
`define TSF_TXD_FALLS 3'h4

`endif

// [shared/tsf_pkg.sv]
// Purpose: shared types of the transceiver status flag logic
// Assumes: nothing beyond the map header
// Notes: used only with explicit package scope
package tsf_pkg;

   // operating modes of the transceiver
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_SILENT,
      MODE_STANDBY,
      MODE_GOSLEEP,
      MODE_SLEEP
   } tsf_mode_type;

   // recorded origin of a rouse
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_LOCAL,
      SRC_BUS
   } tsf_src_type;

   // the status flags as one carrier
   typedef struct packed {
      logic cold;
      logic req;
      tsf_src_type src;
      logic mask;
      logic uvc;
      logic uvi;
   } tsf_flags_type;

endpackage : tsf_pkg

// [logic/tsf_status_flags.sv]
// Purpose: status flags, rouse capture and fault indicator drive of a CAN FD transceiver core
// Assumes: pins already synchronous to clk_i; supply comparators give clean ok levels
// Notes: APB slave with zero wait states; mode request comes from the pin decoder
//
// The address map and register access over APB were decided locally.
`include "tsf_reg_map.svh"

module tsf_status_flags #(
   parameter int UV_FILTER_NS = `TSF_UV_FILTER_NS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`TSF_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // mode and events
   input wire tsf_pkg::tsf_mode_type mode_req_i,
   input wire logic wake_pin_i,
   input wire logic bus_rouse_i,
   input wire logic txd_i,
   input wire logic supply_control_mask_input_i,
   input wire logic ext_fault_i,
   // supply monitors
   input wire logic battery_supply_ok_i,
   input wire logic core_supply_ok_i,
   input wire logic io_supply_ok_i,
   // indicators
   output tsf_pkg::tsf_mode_type mode_o,
   output logic fault_indicator_out_o,
   output logic fault_indicator_oe_o,
   output logic rxd_pull_low_o
);

   // ****************************************
   // constants
   // ****************************************
   localparam int UV_CYC_RAW = (UV_FILTER_NS * `TSF_CLK_MHZ + 999) / 1000;
   localparam int UV_CYC = (UV_CYC_RAW < 1) ? 1 : UV_CYC_RAW;
   localparam int UV_W = $clog2(UV_CYC + 1);
   localparam logic [UV_W-1:0] UV_LIMIT = UV_W'(UV_CYC);
   localparam logic [31:0] CTRL_RST = `TSF_CTRL_RST; // only the low control bits are kept

   // ****************************************
   // state
   // ****************************************
   tsf_pkg::tsf_mode_type mode_q, mode_d;
   tsf_pkg::tsf_flags_type flags_q, flags_d;
   logic [`TSF_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [31:0] prdata_q, prdata_d;
   logic [UV_W-1:0] uvc_cnt_q, uvc_cnt_d, uvi_cnt_q, uvi_cnt_d;
   logic [2:0] txd_cnt_q, txd_cnt_d;
   logic wake_prev_q, bat_prev_q, mask_prev_q, txd_prev_q;
   logic silent_low_q, silent_low_d;
   logic fault_n_q, fault_n_d, fault_oe_q, fault_oe_d, rxd_low_q, rxd_low_d;

   // event terms
   logic local_ev, cold_set, rouse_set, mask_set, chg, uvc_exp, uvi_exp;
   logic txd_fall, txd_fourth, src_clr, enter_normal, rouse_mode;
   tsf_pkg::tsf_src_type new_src;

   // ****************************************
   // apb register access
   // ****************************************
   logic setup, acc_wr, hit_ctrl, hit_status;

   // decode and read data capture in the setup phase
   always_comb
   begin
      setup = psel_i && !penable_i;
      acc_wr = psel_i && penable_i && pwrite_i;
      hit_ctrl = (paddr_i == `TSF_OFF_CTRL);
      hit_status = (paddr_i == `TSF_OFF_STATUS);
      ctrl_d = ctrl_q;
      prdata_d = prdata_q;
      if (acc_wr && hit_ctrl)
      begin
         ctrl_d = pwdata_i[`TSF_CTRL_W-1:0];
      end
      if (setup)
      begin
         prdata_d = 32'h0000_0000;
         if (hit_ctrl)
         begin
            prdata_d[`TSF_CTRL_W-1:0] = ctrl_q;
         end
         else if (hit_status)
         begin
            prdata_d[`TSF_ST_COLD] = flags_q.cold;
            prdata_d[`TSF_ST_REQ] = flags_q.req;
            prdata_d[`TSF_ST_SRC_HI:`TSF_ST_SRC_LO] = flags_q.src;
            prdata_d[`TSF_ST_MASK] = flags_q.mask;
            prdata_d[`TSF_ST_UVC] = flags_q.uvc;
            prdata_d[`TSF_ST_UVI] = flags_q.uvi;
            prdata_d[`TSF_ST_MODE_HI:`TSF_ST_MODE_LO] = mode_q;
         end
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit_ctrl && !hit_status;
   assign prdata_o = prdata_q;

   // ****************************************
   // events and mode
   // ****************************************
   // edge detection and mode steering
   always_comb
   begin
      local_ev = (wake_pin_i != wake_prev_q) && ctrl_q[`TSF_CTRL_LOCAL_EN];
      cold_set = battery_supply_ok_i && !bat_prev_q;
      rouse_mode = (mode_q == tsf_pkg::MODE_STANDBY) || (mode_q == tsf_pkg::MODE_GOSLEEP)
         || (mode_q == tsf_pkg::MODE_SLEEP);
      rouse_set = rouse_mode && (local_ev || cold_set
         || (bus_rouse_i && ctrl_q[`TSF_CTRL_BUS_EN]));
      new_src = (cold_set || local_ev) ? tsf_pkg::SRC_LOCAL : tsf_pkg::SRC_BUS;
      mask_set = supply_control_mask_input_i != mask_prev_q;
      txd_fall = txd_prev_q && !txd_i;
      mode_d = mode_req_i;
      if (mode_req_i == tsf_pkg::MODE_GOSLEEP && flags_q.req && mode_q != tsf_pkg::MODE_GOSLEEP)
      begin
         mode_d = mode_q;
      end
      if (rouse_set && (mode_q == tsf_pkg::MODE_GOSLEEP || mode_q == tsf_pkg::MODE_SLEEP))
      begin
         mode_d = tsf_pkg::MODE_STANDBY;
      end
      chg = mode_d != mode_q;
      enter_normal = chg && (mode_d == tsf_pkg::MODE_NORMAL);
   end

   // ****************************************
   // undervoltage filter timers
   // ****************************************
   // count while the supply is low, restart on a rouse request
   always_comb
   begin
      uvc_cnt_d = uvc_cnt_q;
      uvi_cnt_d = uvi_cnt_q;
      if (core_supply_ok_i || rouse_set)
      begin
         uvc_cnt_d = '0;
      end
      else if (uvc_cnt_q != UV_LIMIT)
      begin
         uvc_cnt_d = uvc_cnt_q + UV_W'(1);
      end
      if (io_supply_ok_i || rouse_set)
      begin
         uvi_cnt_d = '0;
      end
      else if (uvi_cnt_q != UV_LIMIT)
      begin
         uvi_cnt_d = uvi_cnt_q + UV_W'(1);
      end
      uvc_exp = (uvc_cnt_q == UV_LIMIT);
      uvi_exp = (uvi_cnt_q == UV_LIMIT);
   end

   // ****************************************
   // flags
   // ****************************************
   // set wins over clear on every flag
   always_comb
   begin
      flags_d = flags_q;
      txd_cnt_d = txd_cnt_q;
      txd_fourth = 1'b0;
      if (mode_q != tsf_pkg::MODE_NORMAL || flags_q.src == tsf_pkg::SRC_NONE)
      begin
         txd_cnt_d = 3'h0;
      end
      else if (txd_fall)
      begin
         txd_cnt_d = txd_cnt_q + 3'h1;
         txd_fourth = (txd_cnt_d == `TSF_TXD_FALLS);
      end
      src_clr = txd_fourth || uvc_exp || uvi_exp
         || (chg && mode_q == tsf_pkg::MODE_NORMAL);
      // cold start
      if (cold_set)
      begin
         flags_d.cold = 1'b1;
      end
      else if (enter_normal)
      begin
         flags_d.cold = 1'b0;
      end
      // rouse request
      if (rouse_set)
      begin
         flags_d.req = 1'b1;
      end
      else if (enter_normal || uvc_exp || uvi_exp)
      begin
         flags_d.req = 1'b0;
      end
      // rouse source, first one kept
      if (rouse_set && (src_clr || flags_q.src == tsf_pkg::SRC_NONE))
      begin
         flags_d.src = new_src;
      end
      else if (src_clr)
      begin
         flags_d.src = tsf_pkg::SRC_NONE;
      end
      // mask change
      if (mask_set)
      begin
         flags_d.mask = 1'b1;
      end
      else if (chg && mode_d != tsf_pkg::MODE_SILENT)
      begin
         flags_d.mask = 1'b0;
      end
      // supply undervoltage, internal only
      flags_d.uvc = !core_supply_ok_i || (flags_q.uvc && !rouse_set);
      flags_d.uvi = !io_supply_ok_i || (flags_q.uvi && !rouse_set);
      if (core_supply_ok_i)
      begin
         flags_d.uvc = 1'b0;
      end
      if (io_supply_ok_i)
      begin
         flags_d.uvi = 1'b0;
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   // fault indicator and rxd pull-down
   always_comb
   begin
      silent_low_d = silent_low_q;
      if (chg && mode_d == tsf_pkg::MODE_SILENT)
      begin
         silent_low_d = (mode_q == tsf_pkg::MODE_STANDBY) || (mode_q == tsf_pkg::MODE_SLEEP);
      end
      else if (mode_d != tsf_pkg::MODE_SILENT)
      begin
         silent_low_d = 1'b0;
      end
      fault_n_d = !(ext_fault_i
         || (flags_q.cold && mode_q == tsf_pkg::MODE_SILENT && silent_low_q)
         || (flags_q.req && mode_q == tsf_pkg::MODE_STANDBY)
         || (flags_q.src == tsf_pkg::SRC_LOCAL && mode_q == tsf_pkg::MODE_NORMAL)
         || (flags_q.mask && mode_q == tsf_pkg::MODE_SILENT));
      rxd_low_d = flags_q.req && mode_q == tsf_pkg::MODE_STANDBY;
      fault_oe_d = mode_d != tsf_pkg::MODE_SLEEP;
   end

   assign mode_o = mode_q;
   assign fault_indicator_out_o = fault_n_q;
   assign fault_indicator_oe_o = fault_oe_q;
   assign rxd_pull_low_o = rxd_low_q;

   // ****************************************
   // registers
   // ****************************************
   // all state of the block
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_q <= tsf_pkg::MODE_STANDBY;
         flags_q <= '0;
         ctrl_q <= CTRL_RST[`TSF_CTRL_W-1:0];
         prdata_q <= 32'h0000_0000;
         uvc_cnt_q <= '0;
         uvi_cnt_q <= '0;
         txd_cnt_q <= 3'h0;
         wake_prev_q <= 1'b0;
         bat_prev_q <= 1'b0;
         mask_prev_q <= 1'b0;
         txd_prev_q <= 1'b1;
         silent_low_q <= 1'b0;
         fault_n_q <= 1'b1;
         fault_oe_q <= 1'b1;
         rxd_low_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         flags_q <= flags_d;
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
         uvc_cnt_q <= uvc_cnt_d;
         uvi_cnt_q <= uvi_cnt_d;
         txd_cnt_q <= txd_cnt_d;
         wake_prev_q <= wake_pin_i;
         bat_prev_q <= battery_supply_ok_i;
         mask_prev_q <= supply_control_mask_input_i;
         txd_prev_q <= txd_i;
         silent_low_q <= silent_low_d;
         fault_n_q <= fault_n_d;
         fault_oe_q <= fault_oe_d;
         rxd_low_q <= rxd_low_d;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_wake_both_edges: assert property (
      mode_q == tsf_pkg::MODE_STANDBY && ctrl_q[`TSF_CTRL_LOCAL_EN] && wake_pin_i != wake_prev_q
      |=> flags_q.req ##1 !fault_indicator_out_o)
      else $error("wake edge in standby not reported");
   chk_fault_or_ext: assert property (
      ext_fault_i && mode_q != tsf_pkg::MODE_SLEEP |=> !fault_indicator_out_o)
      else $error("external fault not on fault indicator");
   chk_rxd_rouse_low: assert property (
      flags_q.req && mode_q == tsf_pkg::MODE_STANDBY |=> rxd_pull_low_o && !fault_indicator_out_o)
      else $error("rouse request not shown on rxd");
   chk_cold_clear_normal: assert property (
      enter_normal && !cold_set |=> !flags_q.cold)
      else $error("cold start kept after entering normal");
   chk_cold_only_normal: assert property (
      flags_q.cold && !enter_normal |=> flags_q.cold)
      else $error("cold start cleared outside normal entry");
   chk_gosleep_refused: assert property (
      flags_q.req && mode_q != tsf_pkg::MODE_GOSLEEP |=> mode_q != tsf_pkg::MODE_GOSLEEP)
      else $error("go-to-sleep entered with rouse request");
   chk_src_first_kept: assert property (
      flags_q.src != tsf_pkg::SRC_NONE && !src_clr |=> $stable(flags_q.src))
      else $error("rouse source overwritten");
   chk_sleep_release: assert property (
      mode_q == tsf_pkg::MODE_SLEEP |-> !fault_indicator_oe_o)
      else $error("fault indicator driven in sleep");
   chk_mask_in_silent: assert property (
      mask_set && mode_d == tsf_pkg::MODE_SILENT && mode_q == tsf_pkg::MODE_SILENT
      |=> ##1 !fault_indicator_out_o)
      else $error("mask change not reported in silent");
   chk_txd_four_falls: assert property (
      mode_q == tsf_pkg::MODE_NORMAL && !chg && txd_fall && txd_cnt_q == (`TSF_TXD_FALLS - 3'h1)
      && flags_q.src != tsf_pkg::SRC_NONE |=> flags_q.src == tsf_pkg::SRC_NONE)
      else $error("rouse source kept after four txd falls");
   chk_uv_recover: assert property (
      flags_q.uvc && core_supply_ok_i |=> !flags_q.uvc)
      else $error("core undervoltage flag kept after recovery");

   cov_cold_to_normal: cover property (flags_q.cold ##[1:20] enter_normal);
   cov_local_in_sleep: cover property (mode_q == tsf_pkg::MODE_SLEEP && local_ev);
   cov_mask_silent: cover property (mode_q == tsf_pkg::MODE_SILENT && mask_set);

endmodule : tsf_status_flags

// [bench/tsf_ctrl_model.sv]
// Purpose: controller side of the status pins: mode select, transmit data, mask input
// Assumes: drives on the rising edge by non-blocking assignment
// Notes: the mask flip reports whether the fault indicator was high first
module tsf_ctrl_model (
   // clock and observed pin
   input wire logic clk_i,
   input wire logic fault_i,
   // driven pins
   output tsf_pkg::tsf_mode_type mode_req_o,
   output logic txd_o,
   output logic mask_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle pins: standby, recessive, mask low
   initial
   begin
      mode_req_o = tsf_pkg::MODE_STANDBY;
      txd_o = 1'b1;
      mask_o = 1'b0;
   end

   // move the mode select pins to a new mode
   task automatic goto(input tsf_pkg::tsf_mode_type md);
      @(posedge clk_i);
      mode_req_o <= md;
   endtask : goto

   // send n recessive-to-dominant edges on transmit data
   task automatic falls(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         txd_o <= 1'b0;
         repeat (2) @(posedge clk_i);
         txd_o <= 1'b1;
         repeat (2) @(posedge clk_i);
      end
   endtask : falls

   // flip the mask input only after looking at the indicator
   task automatic flip(output logic ok);
      @(negedge clk_i);
      ok = fault_i;
      @(posedge clk_i);
      mask_o <= ~mask_o;
   endtask : flip
endmodule : tsf_ctrl_model

// [bench/test_tsf_status_flags.sv]
// Purpose: self-checking bench of the status flag logic
// Assumes: zero wait APB slave, pins settle two edges after a cause
// Notes: undervoltage filter shortened to ten cycles
`include "tsf_reg_map.svh"

module test_tsf_status_flags;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // signals
   // ****************************************
   logic clk_i, sys_rst_i, psel, penable, pwrite, pready_o, pslverr_o;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_o, q;
   logic wake, bus, ext, bat, core, io, ok, e;
   logic txd, mask, fault, oe, rxd_low;
   tsf_pkg::tsf_mode_type mode_req, mode_o;
   int fail_count = 0;
   int n_compared = 0;

   // ****************************************
   // design and controller
   // ****************************************
   tsf_status_flags #(.UV_FILTER_NS(40)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_req_i(mode_req), .wake_pin_i(wake),
      .bus_rouse_i(bus), .txd_i(txd), .supply_control_mask_input_i(mask), .ext_fault_i(ext),
      .battery_supply_ok_i(bat), .core_supply_ok_i(core), .io_supply_ok_i(io), .mode_o(mode_o),
      .fault_indicator_out_o(fault), .fault_indicator_oe_o(oe), .rxd_pull_low_o(rxd_low));

   tsf_ctrl_model m (.clk_i(clk_i), .fault_i(fault), .mode_req_o(mode_req), .txd_o(txd), .mask_o(mask));

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one APB transfer, waits for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge clk_i);
      end
      while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // status read compared on the defined bits
   task automatic rd(input logic [10:0] exp);
      apb(1'b0, `TSF_OFF_STATUS, 32'h0000_0000);
      chk({21'h0_0000, q[10:0]}, {21'h0_0000, exp});
   endtask : rd

   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask : w

   // fault, rxd pull and drive enable together
   task automatic pins(input logic [2:0] exp);
      chk({29'h0, fault, rxd_low, oe}, {29'h0, exp});
   endtask : pins

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // ****************************************
   // clock, watchdog, sequence
   // ****************************************
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // cut a hang short
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      wrap_up();
   end

   initial
   begin
      {psel, penable, pwrite, wake, bus, ext} = '0;
      {bat, core, io, sys_rst_i} = 4'hF;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      w(4);
      apb(1'b0, `TSF_OFF_CTRL, 32'h0000_0000);
      chk(q, `TSF_CTRL_RST);
      rd(11'h207);
      pins(3'h3);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      chk(q, 32'h0000_0000);
      apb(1'b1, `TSF_OFF_STATUS, 32'h0000_0000);
      rd(11'h207);
      m.goto(tsf_pkg::MODE_GOSLEEP);
      w(4);
      chk(mode_o, tsf_pkg::MODE_STANDBY);
      m.goto(tsf_pkg::MODE_SILENT);
      w(4);
      chk(fault, 1'b0);
      m.goto(tsf_pkg::MODE_NORMAL);
      w(4);
      rd(11'h004);
      chk(fault, 1'b0);
      @(posedge clk_i) wake <= 1'b1;
      w(4);
      rd(11'h004);
      m.falls(3);
      rd(11'h004);
      m.falls(1);
      rd(11'h000);
      chk(fault, 1'b1);
      @(posedge clk_i) ext <= 1'b1;
      w(4);
      chk(fault, 1'b0);
      @(posedge clk_i) ext <= 1'b0;
      // mask flipped inside silent mode once the indicator is high again
      m.goto(tsf_pkg::MODE_SILENT);
      w(4);
      chk(fault, 1'b1);
      m.flip(ok);
      chk(ok, 1'b1);
      w(4);
      chk(fault, 1'b0);
      rd(11'h110);
      m.goto(tsf_pkg::MODE_STANDBY);
      w(4);
      rd(11'h200);
      chk(fault, 1'b1);
      // local rouse disabled: two wake edges are ignored
      apb(1'b1, `TSF_OFF_CTRL, 32'h0000_0002);
      @(posedge clk_i) wake <= 1'b0;
      w(4);
      @(posedge clk_i) wake <= 1'b1;
      w(4);
      rd(11'h200);
      apb(1'b1, `TSF_OFF_CTRL, `TSF_CTRL_RST);
      m.goto(tsf_pkg::MODE_GOSLEEP);
      w(4);
      chk(mode_o, tsf_pkg::MODE_GOSLEEP);
      m.goto(tsf_pkg::MODE_SLEEP);
      w(4);
      chk(oe, 1'b0);
      @(posedge clk_i) wake <= 1'b0;
      w(4);
      m.goto(tsf_pkg::MODE_STANDBY);
      w(4);
      rd(11'h206);
      pins(3'h3);
      @(posedge clk_i) bus <= 1'b1;
      @(posedge clk_i) bus <= 1'b0;
      w(4);
      rd(11'h206);
      @(posedge clk_i) core <= 1'b0;
      w(14);
      rd(11'h220);
      pins(3'h5);
      @(posedge clk_i) core <= 1'b1;
      w(4);
      rd(11'h200);
      @(posedge clk_i) bus <= 1'b1;
      @(posedge clk_i) bus <= 1'b0;
      w(4);
      rd(11'h20A);
      @(posedge clk_i) wake <= 1'b1;
      w(4);
      rd(11'h20A);
      m.goto(tsf_pkg::MODE_NORMAL);
      w(4);
      rd(11'h008);
      chk(fault, 1'b1);
      m.goto(tsf_pkg::MODE_STANDBY);
      w(4);
      rd(11'h200);
      @(posedge clk_i) wake <= 1'b0;
      w(4);
      rd(11'h206);
      @(posedge clk_i) io <= 1'b0;
      w(14);
      rd(11'h240);
      @(posedge clk_i) io <= 1'b1;
      w(4);
      rd(11'h200);
      @(posedge clk_i) bat <= 1'b0;
      w(4);
      @(posedge clk_i) bat <= 1'b1;
      w(4);
      rd(11'h207);
      wrap_up();
   end
endmodule : test_tsf_status_flags
